//--- ict_exec_timing.v
// Purpose: cycle-timing engine for decimal, single-operand, shift
//          and bit instruction groups, with a one-pass shifter
// Assumes: inputs synchronous to clk; address times given by caller
// Notes:   prefetch only in the worst case; reads lead, writes trail
`include "ict_map.vh"

module ict_exec_timing #(
   parameter DW = 32
) (
   input  wire          clk,
   input  wire          rst,
   input  wire          start,
   input  wire [4:0]    opSel,
   input  wire [1:0]    caseSel,
   input  wire          bitImm,
   input  wire [5:0]    fetchEaClk,
   input  wire [5:0]    fetchImmClk,
   input  wire [5:0]    calcEaClk,
   input  wire [DW-1:0] shiftData,
   input  wire [5:0]    shiftCount,
   input  wire          shiftLeft,
   input  wire          extendIn,
   output reg           busy_r,
   output reg           done_r,
   output reg           readStb_r,
   output reg           prefStb_r,
   output reg           writeStb_r,
   output reg  [6:0]    lastTotal_r,
   output reg  [DW-1:0] shiftResult_r,
   output reg           extendOut_r
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_RUN  = 2'b10;
   localparam [5:0] DWS    = DW;      // rotate modulus
   localparam [5:0] DW1    = DW + 1;  // rotate-through-extend modulus

   // ---------------------------------------------------------------
   // timing row lookup: {best, cache, worst, reads, writes, ea kind}
   // ---------------------------------------------------------------
   function [23:0] rowOf;
      input [4:0] op;
      begin
         case (op)
            `ICT_OP_DEC_REG:  rowOf = {6'h04, 6'h04, 6'h05, 2'h0, 2'h0, `ICT_EA_NONE}; // RL2
            `ICT_OP_DEC_MEM:  rowOf = {6'h0e, 6'h10, 6'h11, 2'h2, 2'h1, `ICT_EA_NONE}; // RL3
            `ICT_OP_EXT_REG:  rowOf = {6'h02, 6'h02, 6'h03, 2'h0, 2'h0, `ICT_EA_NONE}; // RL5
            `ICT_OP_EXT_MEM:  rowOf = {6'h0a, 6'h0c, 6'h0d, 2'h2, 2'h1, `ICT_EA_NONE}; // RL5
            `ICT_OP_CMP_MEM:  rowOf = {6'h08, 6'h09, 6'h0a, 2'h2, 2'h0, `ICT_EA_NONE}; // RL6
            `ICT_OP_DIGITS_A_REG: rowOf = {6'h03, 6'h06, 6'h07, 2'h0, 2'h0, `ICT_EA_NONE}; // RL7
            `ICT_OP_PK_MEM:   rowOf = {6'h0b, 6'h0d, 6'h0d, 2'h1, 2'h1, `ICT_EA_NONE}; // RL7
            `ICT_OP_UNPACK_DIGITS_REG: rowOf = {6'h05, 6'h08, 6'h09, 2'h0, 2'h0, `ICT_EA_NONE}; // RL7
            `ICT_OP_SGL_REG:  rowOf = {6'h00, 6'h02, 6'h03, 2'h0, 2'h0, `ICT_EA_NONE}; // RL8
            `ICT_OP_SGL_MEM:  rowOf = {6'h03, 6'h04, 6'h06, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL8
            `ICT_OP_SEXT:     rowOf = {6'h01, 6'h04, 6'h04, 2'h0, 2'h0, `ICT_EA_NONE}; // RL9
            `ICT_OP_DNEG:     rowOf = {6'h06, 6'h06, 6'h06, 2'h0, 2'h0, `ICT_EA_NONE}; // RL9
            `ICT_OP_SCC_REG:  rowOf = {6'h01, 6'h04, 6'h04, 2'h0, 2'h0, `ICT_EA_NONE}; // RL11
            `ICT_OP_SCC_MEM:  rowOf = {6'h06, 6'h06, 6'h06, 2'h0, 2'h1, `ICT_EA_NONE}; // RL11
            `ICT_OP_TAS_REG:  rowOf = {6'h01, 6'h04, 6'h04, 2'h0, 2'h0, `ICT_EA_NONE}; // RL10
            `ICT_OP_TAS_MEM:  rowOf = {6'h0c, 6'h0c, 6'h0d, 2'h1, 2'h1, `ICT_EA_CALC}; // RL10 RL19
            `ICT_OP_LSH_STAT: rowOf = {6'h01, 6'h04, 6'h04, 2'h0, 2'h0, `ICT_EA_NONE}; // RL13
            `ICT_OP_LSH_DYN:  rowOf = {6'h03, 6'h06, 6'h06, 2'h0, 2'h0, `ICT_EA_NONE}; // RL13
            `ICT_OP_LSH_MEM:  rowOf = {6'h05, 6'h05, 6'h06, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL13
            `ICT_OP_ASL_REG:  rowOf = {6'h05, 6'h08, 6'h08, 2'h0, 2'h0, `ICT_EA_NONE}; // RL14
            `ICT_OP_ASR_REG:  rowOf = {6'h03, 6'h06, 6'h06, 2'h0, 2'h0, `ICT_EA_NONE}; // RL14
            `ICT_OP_ASL_MEM:  rowOf = {6'h06, 6'h06, 6'h07, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL14
            `ICT_OP_ASR_MEM:  rowOf = {6'h05, 6'h05, 6'h06, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL14
            `ICT_OP_ROT_REG:  rowOf = {6'h05, 6'h08, 6'h08, 2'h0, 2'h0, `ICT_EA_NONE}; // RL15
            `ICT_OP_ROX_REG:  rowOf = {6'h09, 6'h0c, 6'h0c, 2'h0, 2'h0, `ICT_EA_NONE}; // RL15
            `ICT_OP_ROT_MEM:  rowOf = {6'h07, 6'h07, 6'h07, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL15
            `ICT_OP_ROX_MEM:  rowOf = {6'h05, 6'h05, 6'h06, 2'h0, 2'h1, `ICT_EA_FETCH}; // RL15
            `ICT_OP_BIT_REG:  rowOf = {6'h01, 6'h04, 6'h05, 2'h0, 2'h0, `ICT_EA_NONE}; // RL16
            `ICT_OP_BIT_TEST_MEM: rowOf = {6'h04, 6'h04, 6'h05, 2'h0, 2'h0, `ICT_EA_BITNUM}; // RL17
            `ICT_OP_BMOD_MEM: rowOf = {6'h04, 6'h04, 6'h05, 2'h0, 2'h1, `ICT_EA_BITNUM}; // RL17
            `ICT_OP_CLR_MEM:  rowOf = {6'h03, 6'h04, 6'h06, 2'h0, 2'h1, `ICT_EA_CALC}; // RL8 RL19
            default:          rowOf = {6'h00, 6'h02, 6'h03, 2'h0, 2'h0, `ICT_EA_FETCH}; // RL8
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // bus cycle placement for clock k of a t-clock operation:
   // reads open, the prefetch follows them, writes close the slot
   // ---------------------------------------------------------------
   function [2:0] stbOf;
      input [6:0] k;
      input [6:0] t;
      input [1:0] r;
      input [1:0] w;
      input       p;
      begin
         stbOf[2] = (k < {5'h00, r});                  // RL1
         stbOf[1] = p && (k == {5'h00, r});            // RL1
         stbOf[0] = (({5'h00, w} + k) >= t);           // RL1
      end
   endfunction

   // ---------------------------------------------------------------
   // one-pass shifter: whole count applied in a single level, so
   // the clock count never depends on the distance moved
   // ---------------------------------------------------------------
   function [DW:0] shOne;
      input [DW-1:0] d;
      input          x;
      input [5:0]    c;
      input          lf;
      input [1:0]    kd;
      reg   [2*DW-1:0] dd;
      reg   [2*DW+1:0] dx;
      reg   [5:0]      cr;
      reg   [5:0]      cm;
      begin
         dd = {d, d};
         dx = {x, d, x, d};
         cr = c % DWS;
         cm = (c >= DW1) ? (c - DW1) : c;
         case (kd)
            `ICT_SH_LOG: shOne = lf ? {x, d << c} : {x, d >> c}; // RL12
            `ICT_SH_ARI: shOne = lf ? {x, d << c} : {x, $signed(d) >>> c};
            `ICT_SH_ROT: begin
               if (lf) begin
                  dd = dd << cr;
                  shOne = {x, dd[2*DW-1:DW]};
               end else begin
                  dd = dd >> cr;
                  shOne = {x, dd[DW-1:0]};
               end
            end
            default: begin
               // extend bit rides along as the top of the word
               if (lf) begin
                  dx = dx << cm;
                  shOne = dx[2*DW+1:DW+1];
               end else begin
                  dx = dx >> cm;
                  shOne = dx[DW:0];
               end
            end
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   reg  [1:0]  state_r;          // one-hot control state
   reg  [6:0]  kCnt_r;           // clock index inside the operation
   reg  [6:0]  tot_r;            // total clocks of the running op
   reg  [1:0]  rdN_r;            // operand reads of the running op
   reg  [1:0]  wrN_r;            // operand writes of the running op
   reg         pf_r;             // prefetch owed by the running op
   reg  [5:0]  base;             // table clocks for the chosen case
   reg  [5:0]  eaAdd;            // address time added on top
   reg  [1:0]  shKind;           // shifter flavour of the request
   wire [23:0] row    = rowOf(opSel);
   wire        worst  = (caseSel != `ICT_CASE_BEST) && (caseSel != `ICT_CASE_CACHE);
   wire [6:0]  totNxt = {1'b0, base} + {1'b0, eaAdd};
   wire [6:0]  kNxt   = kCnt_r + 7'h01;
   wire [DW:0] shOut  = shOne(shiftData, extendIn, shiftCount, shiftLeft, shKind);
   wire [2:0]  stb0   = stbOf(7'h00, totNxt, row[5:4], row[3:2], worst);
   wire [2:0]  stbK   = stbOf(kNxt, tot_r, rdN_r, wrN_r, pf_r);

   // case column and address time selection
   always @* begin
      case (caseSel)
         `ICT_CASE_BEST:  base = row[23:18]; // RL20
         `ICT_CASE_CACHE: base = row[17:12]; // RL20
         default:         base = row[11:6];  // RL20
      endcase
      case (row[1:0])
         `ICT_EA_NONE:   eaAdd = 6'h00;                            // RL4
         `ICT_EA_FETCH:  eaAdd = fetchEaClk;
         `ICT_EA_BITNUM: eaAdd = bitImm ? fetchImmClk : fetchEaClk; // RL18
         default:        eaAdd = calcEaClk;                        // RL19
      endcase
   end

   // shifter flavour follows the op code; non-shift ops pass logical
   always @* begin
      case (opSel)
         `ICT_OP_ASL_REG, `ICT_OP_ASR_REG,
         `ICT_OP_ASL_MEM, `ICT_OP_ASR_MEM: shKind = `ICT_SH_ARI;
         `ICT_OP_ROT_REG, `ICT_OP_ROT_MEM: shKind = `ICT_SH_ROT;
         `ICT_OP_ROX_REG, `ICT_OP_ROX_MEM: shKind = `ICT_SH_ROX;
         default:                          shKind = `ICT_SH_LOG;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer: busy for exactly the total, done one clock after
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state_r       <= S_IDLE;
         kCnt_r        <= 7'h00;
         tot_r         <= 7'h00;
         rdN_r         <= 2'h0;
         wrN_r         <= 2'h0;
         pf_r          <= 1'b0;
         busy_r        <= 1'b0;
         done_r        <= 1'b0;
         readStb_r     <= 1'b0;
         prefStb_r     <= 1'b0;
         writeStb_r    <= 1'b0;
         lastTotal_r   <= 7'h00;
         shiftResult_r <= {DW{1'b0}};
         extendOut_r   <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               done_r <= 1'b0;
               if (start) begin
                  // result is settled in the accept clock, whatever the count
                  shiftResult_r <= shOut[DW-1:0]; // RL12
                  extendOut_r   <= shOut[DW];
                  tot_r         <= totNxt;
                  rdN_r         <= row[5:4];
                  wrN_r         <= row[3:2];
                  pf_r          <= worst;
                  kCnt_r        <= 7'h00;
                  if (totNxt == 7'h00) begin
                     // fully overlapped op: no busy clock at all
                     done_r      <= 1'b1; // RL8
                     lastTotal_r <= 7'h00;
                  end else begin
                     state_r    <= S_RUN;
                     busy_r     <= 1'b1;
                     readStb_r  <= stb0[2]; // RL1
                     prefStb_r  <= stb0[1];
                     writeStb_r <= stb0[0];
                  end
               end
            end
            S_RUN: begin
               if (kNxt == tot_r) begin
                  // last clock served; bus cycles all fell inside it
                  state_r     <= S_IDLE;
                  busy_r      <= 1'b0;
                  done_r      <= 1'b1;
                  readStb_r   <= 1'b0;
                  prefStb_r   <= 1'b0;
                  writeStb_r  <= 1'b0;
                  lastTotal_r <= tot_r; // RL20
               end else begin
                  kCnt_r     <= kNxt;
                  readStb_r  <= stbK[2]; // RL1
                  prefStb_r  <= stbK[1];
                  writeStb_r <= stbK[0];
               end
            end
            default: begin
               // illegal code: fall back quietly to idle
               state_r    <= S_IDLE;
               busy_r     <= 1'b0;
               readStb_r  <= 1'b0;
               prefStb_r  <= 1'b0;
               writeStb_r <= 1'b0;
            end
         endcase
      end
   end

endmodule // ict_exec_timing

//--- ict_map.vh
// Purpose: constants for the integer execution timing engine
// Assumes: one core clock; op codes select a timing row
// Notes:   row tuples live in the engine's lookup function
// Contract
// RL1: bus cycles counted inside each total
// RL2: decimal register form 4/4/5 clocks
// RL3: decimal memory form 14/16/17, two reads
// RL4: no address time for decimal group
// RL5: extended ops 2/2/3 and 10/12/13
// RL6: memory compare 8/9/10, two reads
// RL7: digits_a 3/6/7, unpack 5/8/9, memory 11/13/13
// RL8: single operand register 0/2/3, memory 3/4/6
// RL9: decimal negate 6 always, sign extend 1/4/4
// RL10: test-and-set memory 12/12/13, register 1/4/4
// RL11: conditional set register 1/4/4, memory 6
// RL12: shift time independent of shift count
// RL13: logical shift 1/4/4, 3/6/6, memory 5/5/6
// RL14: arithmetic shifts 5/8/8, 3/6/6, memory 6/6/7, 5/5/6
// RL15: rotate 5/8/8, extend 9/12/12, memory 7, 5/5/6
// RL16: bit op register 1/4/5 clocks
// RL17: bit op memory 4/4/5, test no write
// RL18: immediate bit number adds fetch-immediate time
// RL19: clear and test-and-set add calculate time
// RL20: per-case clock and bus cycle accounting
`ifndef ICT_MAP_VH
`define ICT_MAP_VH
// ---------------------------------------------------------------
// timing case select
// ---------------------------------------------------------------
`define ICT_CASE_BEST   2'h0
`define ICT_CASE_CACHE  2'h1
// ---------------------------------------------------------------
// address time kinds carried in a row
// ---------------------------------------------------------------
`define ICT_EA_NONE     2'h0
`define ICT_EA_FETCH    2'h1
`define ICT_EA_BITNUM   2'h2
`define ICT_EA_CALC     2'h3
// ---------------------------------------------------------------
// operation codes, one per timing row
// ---------------------------------------------------------------
`define ICT_OP_DEC_REG  5'h00
`define ICT_OP_DEC_MEM  5'h01
`define ICT_OP_EXT_REG  5'h02
`define ICT_OP_EXT_MEM  5'h03
`define ICT_OP_CMP_MEM  5'h04
`define ICT_OP_DIGITS_A_REG 5'h05
`define ICT_OP_PK_MEM   5'h06
`define ICT_OP_UNPACK_DIGITS_REG 5'h07
`define ICT_OP_SGL_REG  5'h08
`define ICT_OP_SGL_MEM  5'h09
`define ICT_OP_SEXT     5'h0a
`define ICT_OP_DNEG     5'h0b
`define ICT_OP_SCC_REG  5'h0c
`define ICT_OP_SCC_MEM  5'h0d
`define ICT_OP_TAS_REG  5'h0e
`define ICT_OP_TAS_MEM  5'h0f
`define ICT_OP_LSH_STAT 5'h10
`define ICT_OP_LSH_DYN  5'h11
`define ICT_OP_LSH_MEM  5'h12
`define ICT_OP_ASL_REG  5'h13
`define ICT_OP_ASR_REG  5'h14
`define ICT_OP_ASL_MEM  5'h15
`define ICT_OP_ASR_MEM  5'h16
`define ICT_OP_ROT_REG  5'h17
`define ICT_OP_ROX_REG  5'h18
`define ICT_OP_ROT_MEM  5'h19
`define ICT_OP_ROX_MEM  5'h1a
`define ICT_OP_BIT_REG  5'h1b
`define ICT_OP_BIT_TEST_MEM 5'h1c
`define ICT_OP_BMOD_MEM 5'h1d
`define ICT_OP_CLR_MEM  5'h1e
`define ICT_OP_TST_EA   5'h1f
// ---------------------------------------------------------------
// shifter kinds
// ---------------------------------------------------------------
`define ICT_SH_LOG      2'h0
`define ICT_SH_ARI      2'h1
`define ICT_SH_ROT      2'h2
`define ICT_SH_ROX      2'h3
`endif

//--- ict_exec_timing_asserts.sv
// Purpose: port-level timing checks for the execution timing engine
// Assumes: one clock, synchronous active-high reset
// Notes:   fixed-figure rows are the forms without address time
`include "ict_map.vh"
module ict_exec_timing_asserts #(parameter DW = 32) (
   input logic          clk,
   input logic          rst,
   input logic          start,
   input logic [4:0]    opSel,
   input logic [1:0]    caseSel,
   input logic          bitImm,
   input logic [5:0]    fetchEaClk,
   input logic [5:0]    fetchImmClk,
   input logic [5:0]    calcEaClk,
   input logic [DW-1:0] shiftData,
   input logic [5:0]    shiftCount,
   input logic          shiftLeft,
   input logic          extendIn,
   input logic          busy_r,
   input logic          done_r,
   input logic          readStb_r,
   input logic          prefStb_r,
   input logic          writeStb_r,
   input logic [6:0]    lastTotal_r,
   input logic [DW-1:0] shiftResult_r,
   input logic          extendOut_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // -------------------------------------------------------------
   // sequences: request taken, operation closed
   // -------------------------------------------------------------
   sequence s_take(logic [4:0] op, logic [1:0] cs);
      start && !busy_r && opSel == op && caseSel == cs;
   endsequence
   sequence s_end(logic [6:0] t);
      !busy_r && done_r && lastTotal_r == t;
   endsequence
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_dec_reg: assert property (s_take(`ICT_OP_DEC_REG, 2'h0) |=> busy_r[*4] ##1 s_end(7'h04))
      else $error("decimal register timing wrong");
   a_dec_mem: assert property (s_take(`ICT_OP_DEC_MEM, 2'h3) |=> readStb_r[*2] ##1 (prefStb_r && !readStb_r))
      else $error("decimal memory strobe order wrong");
   a_single_zero: assert property (s_take(`ICT_OP_SGL_REG, 2'h0) |=> s_end(7'h00))
      else $error("zero clock operation wrong");
   a_shift_flat: assert property (s_take(`ICT_OP_LSH_DYN, 2'h0) |=> busy_r[*3] ##1 s_end(7'h03))
      else $error("dynamic shift timing wrong");
   a_rox_reg: assert property (s_take(`ICT_OP_ROX_REG, 2'h0) |=> busy_r[*8] ##1 busy_r ##1 s_end(7'h09))
      else $error("rotate extend timing wrong");
   // -------------------------------------------------------------
   // request in flight, latched where the engine takes it, so the
   // strobe checks need no open-ended window
   // -------------------------------------------------------------
   logic worstTaken_r;    // worst case was taken
   logic bitTestTaken_r;  // memory bit test was taken
   always @(posedge clk) begin
      if (rst) begin
         worstTaken_r   <= 1'b0;
         bitTestTaken_r <= 1'b0;
      end else if (start && !busy_r) begin
         worstTaken_r   <= caseSel[1];
         bitTestTaken_r <= (opSel == `ICT_OP_BIT_TEST_MEM);
      end
   end
   a_pref_fast: assert property (prefStb_r |-> worstTaken_r)
      else $error("prefetch outside worst case");
   a_bit_nowrite: assert property (writeStb_r |-> !bitTestTaken_r)
      else $error("bit test wrote memory");
   a_busy_done: assert property ($fell(busy_r) |-> done_r)
      else $error("done missing after busy");
   a_done_idle: assert property (done_r |-> !busy_r)
      else $error("done while busy");
   a_busy_bound: assert property ($rose(busy_r) |-> ##[1:100] done_r)
      else $error("operation never completed");
endmodule // ict_exec_timing_asserts

bind ict_exec_timing ict_exec_timing_asserts #(.DW(DW)) u_chk (
   .clk(clk), .rst(rst), .start(start), .opSel(opSel), .caseSel(caseSel), .bitImm(bitImm),
   .fetchEaClk(fetchEaClk), .fetchImmClk(fetchImmClk), .calcEaClk(calcEaClk),
   .shiftData(shiftData), .shiftCount(shiftCount), .shiftLeft(shiftLeft), .extendIn(extendIn),
   .busy_r(busy_r), .done_r(done_r), .readStb_r(readStb_r), .prefStb_r(prefStb_r),
   .writeStb_r(writeStb_r), .lastTotal_r(lastTotal_r), .shiftResult_r(shiftResult_r),
   .extendOut_r(extendOut_r));

//--- ict_exec_timing_tb.sv
// Purpose: self-checking bench for the execution timing engine
// Assumes: address times held at 3 fetch, 5 immediate, 7 calculate
// Notes:   worst case driven as 2 in the tables, as 3 in the refusal run
`include "ict_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FEA = 3;       // fetch address clocks
   localparam int FIM = 5;       // fetch immediate clocks
   localparam int CEA = 7;       // calculate address clocks
   logic        clk, rst, start, bitImm, shiftLeft, extendIn;
   logic [4:0]  opSel;
   logic [1:0]  caseSel;
   logic [5:0]  fetchEaClk, fetchImmClk, calcEaClk, shiftCount;
   logic [31:0] shiftData, shiftResult_r;
   logic        busy_r, done_r, readStb_r, prefStb_r, writeStb_r, extendOut_r;
   logic [6:0]  lastTotal_r;
   int          failures, cmp_count;

   ict_exec_timing #(.DW(32)) DUT (
      .clk(clk), .rst(rst), .start(start), .opSel(opSel), .caseSel(caseSel), .bitImm(bitImm),
      .fetchEaClk(fetchEaClk), .fetchImmClk(fetchImmClk), .calcEaClk(calcEaClk),
      .shiftData(shiftData), .shiftCount(shiftCount), .shiftLeft(shiftLeft),
      .extendIn(extendIn), .busy_r(busy_r), .done_r(done_r), .readStb_r(readStb_r),
      .prefStb_r(prefStb_r), .writeStb_r(writeStb_r), .lastTotal_r(lastTotal_r),
      .shiftResult_r(shiftResult_r), .extendOut_r(extendOut_r));
   // -------------------------------------------------------------
   // shared helpers
   // -------------------------------------------------------------
   task automatic check(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one start pulse, inputs moved just after an edge
   task automatic launch(logic [4:0] op, logic [1:0] cs);
      @(posedge clk);
      #1;
      start = 1'h1;
      opSel = op;
      caseSel = cs;
      bitImm = (cs == 2'h0);
      @(posedge clk);
      #1;
      start = 1'h0;
   endtask
   // counts busy clocks and strobes until done, bounded
   task automatic measure(string nm, int t, int lt, int r, int p, int w);
      int nb, nr, np, nw, i;
      nb = 0;
      nr = 0;
      np = 0;
      nw = 0;
      for (i = 0; i < 200 && done_r !== 1'h1; i++) begin
         nb += (busy_r === 1'h1);
         nr += (readStb_r === 1'h1);
         np += (prefStb_r === 1'h1);
         nw += (writeStb_r === 1'h1);
         @(posedge clk);
         #1;
      end
      if (i == 200) begin
         failures++;
         finish_test();
      end
      check({nm, " busy"}, t, nb);
      check({nm, " reads"}, r, nr);
      check({nm, " prefetch"}, p, np);
      check({nm, " writes"}, w, nw);
      check({nm, " total"}, lt, {25'h0, lastTotal_r});
   endtask
   // all three cases of one row, address time per kind
   task automatic row(logic [4:0] op, int b, int c, int wc, int r, int w, logic [1:0] ea);
      int cs, add, t;
      for (cs = 0; cs < 3; cs++) begin
         add = (ea == `ICT_EA_FETCH) ? FEA : (ea == `ICT_EA_CALC) ? CEA : 0;
         if (ea == `ICT_EA_BITNUM) add = (cs == 0) ? FIM : FEA;
         t = ((cs == 0) ? b : (cs == 1) ? c : wc) + add;
         launch(op, 2'(cs));
         measure($sformatf("op %0h case %0d", op, cs), t, t, r, cs == 2, w);
      end
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_decimal();
      row(`ICT_OP_DEC_REG, 4, 4, 5, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_DEC_MEM, 14, 16, 17, 2, 1, `ICT_EA_NONE);
      row(`ICT_OP_EXT_REG, 2, 2, 3, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_EXT_MEM, 10, 12, 13, 2, 1, `ICT_EA_NONE);
      row(`ICT_OP_CMP_MEM, 8, 9, 10, 2, 0, `ICT_EA_NONE);
      row(`ICT_OP_DIGITS_A_REG, 3, 6, 7, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_PK_MEM, 11, 13, 13, 1, 1, `ICT_EA_NONE);
      row(`ICT_OP_UNPACK_DIGITS_REG, 5, 8, 9, 0, 0, `ICT_EA_NONE);
   endtask
   task automatic t_single();
      row(`ICT_OP_SGL_REG, 0, 2, 3, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_SGL_MEM, 3, 4, 6, 0, 1, `ICT_EA_FETCH);
      row(`ICT_OP_CLR_MEM, 3, 4, 6, 0, 1, `ICT_EA_CALC);
      row(`ICT_OP_TST_EA, 0, 2, 3, 0, 0, `ICT_EA_FETCH);
      row(`ICT_OP_SEXT, 1, 4, 4, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_DNEG, 6, 6, 6, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_SCC_REG, 1, 4, 4, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_SCC_MEM, 6, 6, 6, 0, 1, `ICT_EA_NONE);
      row(`ICT_OP_TAS_REG, 1, 4, 4, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_TAS_MEM, 12, 12, 13, 1, 1, `ICT_EA_CALC);
   endtask
   task automatic t_shift();
      row(`ICT_OP_LSH_STAT, 1, 4, 4, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_LSH_DYN, 3, 6, 6, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_LSH_MEM, 5, 5, 6, 0, 1, `ICT_EA_FETCH);
      row(`ICT_OP_ASL_REG, 5, 8, 8, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_ASR_REG, 3, 6, 6, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_ASL_MEM, 6, 6, 7, 0, 1, `ICT_EA_FETCH);
      row(`ICT_OP_ASR_MEM, 5, 5, 6, 0, 1, `ICT_EA_FETCH);
      row(`ICT_OP_ROT_REG, 5, 8, 8, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_ROX_REG, 9, 12, 12, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_ROT_MEM, 7, 7, 7, 0, 1, `ICT_EA_FETCH);
      row(`ICT_OP_ROX_MEM, 5, 5, 6, 0, 1, `ICT_EA_FETCH);
   endtask
   task automatic t_bits();
      row(`ICT_OP_BIT_REG, 1, 4, 5, 0, 0, `ICT_EA_NONE);
      row(`ICT_OP_BIT_TEST_MEM, 4, 4, 5, 0, 0, `ICT_EA_BITNUM);
      row(`ICT_OP_BMOD_MEM, 4, 4, 5, 0, 1, `ICT_EA_BITNUM);
   endtask
   // one shifter request, result and extend judged after it closes
   task automatic shift_one(string nm, logic [4:0] op, int t, logic lf, logic [5:0] c,
                            logic [32:0] e);
      shiftCount = c;
      shiftLeft = lf;
      launch(op, 2'h0);
      measure(nm, t, t, 0, 0, 0);
      check({nm, " result"}, e[31:0], shiftResult_r);
      check({nm, " extend"}, {31'h0, e[32]}, {31'h0, extendOut_r});
   endtask
   // same clocks for short and long distances, both directions
   task automatic t_count();
      int i;
      logic [32:0] x;
      for (i = 0; i < 4; i++) begin
         shiftCount = 6'(i * 10 + 1);
         shiftLeft = i[0];
         launch(`ICT_OP_LSH_DYN, 2'h0);
         measure("flat shift", 3, 3, 0, 0, 0);
         check("shift result", i[0] ? shiftData << shiftCount : shiftData >> shiftCount,
               shiftResult_r);
      end
      // rotate, rotate-through-extend and arithmetic flavours too
      x = {extendIn, shiftData};
      x = (x << 4) | (x >> 29);
      shift_one("rotx left", `ICT_OP_ROX_REG, 9, 1'h1, 6'h04, x);
      x = {extendIn, shiftData >> 8 | shiftData << 24};
      shift_one("rot right", `ICT_OP_ROT_REG, 5, 1'h0, 6'h08, x);
      x = {extendIn, {4{shiftData[31]}}, shiftData[31:4]};
      shift_one("asr right", `ICT_OP_ASR_REG, 3, 1'h0, 6'h04, x);
   endtask
   // second start while busy must be ignored
   task automatic t_refuse();
      @(posedge clk);
      #1;
      start = 1'h1;
      opSel = `ICT_OP_DEC_MEM;
      caseSel = 2'h3;
      @(posedge clk);
      #1;
      opSel = `ICT_OP_SGL_REG;
      @(posedge clk);
      #1;
      start = 1'h0;
      measure("refused start", 16, 17, 1, 1, 1);
   endtask
   // -------------------------------------------------------------
   // clock and main sequence
   // -------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst = 1'h1;
      start = 1'h0;
      opSel = 5'h00;
      caseSel = 2'h0;
      bitImm = 1'h0;
      fetchEaClk = 6'(FEA);
      fetchImmClk = 6'(FIM);
      calcEaClk = 6'(CEA);
      shiftData = 32'h8421_0f3c;
      shiftCount = 6'h00;
      shiftLeft = 1'h1;
      extendIn = 1'h1;
      failures = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      #1 rst = 1'h0;
      t_decimal();
      t_single();
      t_shift();
      t_bits();
      t_count();
      t_refuse();
      finish_test();
   end
endmodule // testbench
